/* pkg/dma_status_pkg.sv */
// constants for the dma channel status monitor
// assumes a 32-bit axi4-lite register bus
package dma_status_pkg;
    localparam int num_channels = 16;
    localparam int num_levels = 4;
    localparam logic [7:0] off_irq_summary = 8'h24;
    localparam logic [7:0] off_busy_vector = 8'h28;
    localparam logic [7:0] off_pending_vector = 8'h2C;
    localparam logic [7:0] off_active_state = 8'h30;
    localparam logic [31:0] reset_value = 32'h00000000;
    localparam int pos_block_count = 16;
    localparam int pos_active_busy = 15;
    localparam int pos_active_index = 8;
    localparam int pos_level_exec = 0;
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;
endpackage

/* rtl/dma_channel_status_monitor.sv */
// dma channel status monitor: per-channel vectors and active channel state
// assumes all event inputs come from controller logic on aclk
// What this block does
// (RULE1) a channel's interrupt summary bit is set while it has a pending interrupt.
// (RULE2) the summary bit clears when its interrupts are disabled or its sources cleared.
// (RULE3) a busy bit clears on trigger completion, bus error or channel disable.
// (RULE4) a busy bit sets when its channel starts a transfer.
// (RULE5) a pending bit clears on trigger start, bus error or channel disable.
// (RULE6) a pending bit sets while a transfer request waits on the channel.
// (RULE7) the active block count shows in bits 31:16 of the active state register.
// (RULE8) on a new grant the held count is written back to the previous channel.
// (RULE9) the active count is meaningful only while the active busy flag is set.
// (RULE10) the active busy flag clears once the count has been written back.
// (RULE11) the active busy flag sets when the next count is read from write-back memory.
// (RULE12) bits 12:8 hold the index of the channel in the active registers.
// (RULE13) that index updates on every new arbiter grant.
// (RULE14) a level indicator sets while any request at that level runs or waits.
// (RULE15) a level indicator clears when no request at that level runs or waits.
// (RULE16) writes have no effect and unused bits read zero.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_status_monitor
    import dma_status_pkg::*;
#(
    parameter int channels = num_channels,
    parameter int levels = num_levels
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [channels-1:0] chan_irq_flags,
    input wire logic [channels-1:0] chan_irq_enables,
    input wire logic [channels-1:0] transfer_start,
    input wire logic [channels-1:0] trigger_complete,
    input wire logic [channels-1:0] trigger_start,
    input wire logic [channels-1:0] request_waiting,
    input wire logic [channels-1:0] bus_error,
    input wire logic [channels-1:0] chan_disable,
    input wire logic [2*channels-1:0] chan_level,
    input wire logic grant_valid,
    input wire logic [4:0] grant_index,
    input wire logic count_load,
    input wire logic [15:0] count_load_value,
    input wire logic count_update,
    input wire logic [15:0] count_update_value,
    output logic writeback_valid,
    output logic [4:0] writeback_index,
    output logic [15:0] writeback_count,
    input wire logic writeback_done
);
    logic [channels-1:0] chan_irq_pending_bit;
    logic [channels-1:0] chan_busy_bit;
    logic [channels-1:0] chan_waiting_bit;
    logic [15:0] active_block_count;
    logic active_chan_busy_flag;
    logic [4:0] active_chan_index;
    logic [levels-1:0] level_exec_indicator;
    logic [levels-1:0] next_level_exec;
    logic [channels-1:0][levels-1:0] chan_level_hit;
    logic aw_held;
    logic w_held;
    logic write_fire;
    logic read_fire;
    logic writeback_issue;
    logic [31:0] active_state_word;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // summary follows enabled flags
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            chan_irq_pending_bit <= '0;
        else
            chan_irq_pending_bit <= chan_irq_flags & chan_irq_enables; // RULE1 RULE2
    end

    // busy and pending per channel; set wins over clear, except that trigger_start blocks the pending set
    genvar g;
    generate
        for (g = 0; g < channels; g = g + 1)
        begin : g_chan
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    chan_busy_bit[g] <= 1'b0;
                else if (transfer_start[g])
                    chan_busy_bit[g] <= 1'b1; // RULE4
                else if (trigger_complete[g] || bus_error[g] || chan_disable[g])
                    chan_busy_bit[g] <= 1'b0; // RULE3
            end
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    chan_waiting_bit[g] <= 1'b0;
                else if (request_waiting[g] && !trigger_start[g])
                    chan_waiting_bit[g] <= 1'b1; // RULE6
                else if (trigger_start[g] || bus_error[g] || chan_disable[g])
                    chan_waiting_bit[g] <= 1'b0; // RULE5
            end
        end
    endgenerate

    // one-hot level of each busy or pending channel
    generate
        for (g = 0; g < channels; g = g + 1)
        begin : g_level
            always_comb
            begin
                chan_level_hit[g] = '0;
                if (chan_busy_bit[g] || chan_waiting_bit[g])
                    chan_level_hit[g][chan_level[2*g +: 2]] = 1'b1; // RULE14
            end
        end
    endgenerate

    // level indicators gather every channel's contribution
    always_comb
    begin
        next_level_exec = '0;
        for (int c = 0; c < channels; c++)
        begin
            next_level_exec = next_level_exec | chan_level_hit[c]; // RULE14 RULE15
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            level_exec_indicator <= '0;
        else
            level_exec_indicator <= next_level_exec;
    end

    // active channel index and count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            active_chan_index <= '0;
        else if (grant_valid)
            active_chan_index <= grant_index; // RULE13
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            active_block_count <= '0;
        else if (count_load)
            active_block_count <= count_load_value;
        else if (count_update)
            active_block_count <= count_update_value;
    end

    // load sets the flag, write-back completion clears it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            active_chan_busy_flag <= 1'b0;
        else if (count_load)
            active_chan_busy_flag <= 1'b1; // RULE11
        else if (writeback_done)
            active_chan_busy_flag <= 1'b0; // RULE10
    end

    // write-back request to previous channel on new grant
    assign writeback_issue = grant_valid && active_chan_busy_flag && !writeback_valid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            writeback_valid <= 1'b0;
            writeback_index <= '0;
            writeback_count <= '0;
        end
        else if (writeback_issue)
        begin
            writeback_valid <= 1'b1; // RULE8
            writeback_index <= active_chan_index;
            writeback_count <= active_block_count;
        end
        else if (writeback_done)
            writeback_valid <= 1'b0;
    end

    // axi write channel: accepted and discarded
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign write_fire = !s_axi_bvalid && (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid);

    // address half kept until its data arrives
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            aw_held <= 1'b0;
        else if (write_fire)
            aw_held <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready)
            aw_held <= 1'b1;
    end

    // data half kept until its address arrives
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            w_held <= 1'b0;
        else if (write_fire)
            w_held <= 1'b0;
        else if (s_axi_wvalid && s_axi_wready)
            w_held <= 1'b1;
    end

    // one response once both halves are in
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_bvalid <= 1'b0;
        else if (write_fire)
            s_axi_bvalid <= 1'b1;
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // read-only registers: every write answered okay, contents unchanged
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_bresp <= resp_okay;
        else if (write_fire)
            s_axi_bresp <= resp_okay; // RULE16
    end

    // active state word: count, busy flag, index, level bits, rest zero
    always_comb
    begin
        active_state_word = reset_value;
        active_state_word[pos_block_count +: 16] = active_block_count; // RULE7 RULE9
        active_state_word[pos_active_busy] = active_chan_busy_flag;
        active_state_word[pos_active_index +: 5] = active_chan_index; // RULE12
        active_state_word[pos_level_exec +: levels] = level_exec_indicator;
    end

    // read decode, unused bits stay zero
    always_comb
    begin
        next_rdata = reset_value;
        next_rresp = resp_okay;
        case (s_axi_araddr[7:0])
            off_irq_summary: next_rdata[channels-1:0] = chan_irq_pending_bit;
            off_busy_vector: next_rdata[channels-1:0] = chan_busy_bit;
            off_pending_vector: next_rdata[channels-1:0] = chan_waiting_bit;
            off_active_state: next_rdata = active_state_word;
            default: next_rresp = resp_slverr; // RULE16
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign read_fire = s_axi_arvalid && s_axi_arready;

    // read answer stands until the master takes it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_rvalid <= 1'b0;
        else if (read_fire)
            s_axi_rvalid <= 1'b1;
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // read data captured as the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rdata <= reset_value;
            s_axi_rresp <= resp_okay;
        end
        else if (read_fire)
        begin
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end
endmodule // dma_channel_status_monitor
`default_nettype wire

/* test/dma_channel_status_monitor_sva.sv */
// checker for the dma channel status monitor ports
// assumes binding into the top module, single aclk domain
`timescale 1ns/1ps
`default_nettype none
module dma_status_checker
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic grant_valid,
    input wire logic writeback_valid,
    input wire logic [4:0] writeback_index,
    input wire logic [15:0] writeback_count,
    input wire logic writeback_done
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    bresp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response waits");
    ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read ready wrong");
    rsp_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    wb_hold_a: assert property (writeback_valid && !writeback_done |=> writeback_valid
        && $stable(writeback_index) && $stable(writeback_count))
        else $error("write-back request changed");
    wb_end_a: assert property (writeback_valid && writeback_done |=> !writeback_valid)
        else $error("write-back not ended");
    wb_cause_a: assert property (!writeback_valid && !grant_valid |=> !writeback_valid)
        else $error("write-back without grant");
endmodule // dma_status_checker
`default_nettype wire

/* test/dma_channel_status_monitor_tb_top.sv */
// testbench for the dma channel status monitor
// assumes the design package is compiled first
`timescale 1ns/1ps
`default_nettype none
module dma_channel_status_monitor_tb_top;
    import dma_status_pkg::*;
    logic aclk = '0, aresetn = '0, grant_valid = '0, count_load = '0, count_update = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, writeback_done = '0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, chan_level = '0;
    logic [15:0] chan_irq_flags = '0, chan_irq_enables = '0, transfer_start = '0;
    logic [15:0] trigger_complete = '0, trigger_start = '0, request_waiting = '0;
    logic [15:0] bus_error = '0, chan_disable = '0, count_load_value = '0, count_update_value = '0;
    logic [4:0] grant_index = '0, writeback_index;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, writeback_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    logic [15:0] writeback_count;
    logic [47:0] tbl [5] = '{48'h0001_0001_0001, 48'h8001_0001_0001, 48'hF0F0_FF00_F000,
        48'h0000_FFFF_0000, 48'hFFFF_FFFF_FFFF};
    int error_cnt = 0, checks_done = 0, i, k;
    always #4 aclk = ~aclk;
    dma_channel_status_monitor dma_channel_status_monitor_inst (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan_irq_flags,
        .chan_irq_enables, .transfer_start, .trigger_complete, .trigger_start, .request_waiting,
        .bus_error, .chan_disable, .chan_level, .grant_valid, .grant_index, .count_load,
        .count_load_value, .count_update, .count_update_value, .writeback_valid,
        .writeback_index, .writeback_count, .writeback_done);
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= '1;
        s_axi_rready <= '1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= '0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= '0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= '0;
            if (s_axi_wready) s_axi_wvalid <= '0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= '0;
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= '1;
        chan_level <= 32'h80;
        for (i = 0; i < 5; i++)
        begin
            chan_irq_flags <= tbl[i][47:32];
            chan_irq_enables <= tbl[i][31:16];
            rd(off_irq_summary);
            chk(d, {16'h0, tbl[i][15:0]});
            chk({30'h0, r}, {30'h0, resp_okay});
        end
        $display("test summary done");
        for (k = 0; k < 3; k++)
        begin
            {transfer_start, request_waiting} <= {16'h8, 16'h8};
            chan_level <= 32'(k + 1) << 6;
            @(posedge aclk);
            {transfer_start, request_waiting} <= '0;
            rd(off_busy_vector);
            chk(d, 32'h8);
            rd(off_pending_vector);
            chk(d, 32'h8);
            rd(off_active_state);
            chk(d & 32'hF, 32'h1 << (k + 1));
            {trigger_complete, trigger_start} <= (k == 0) ? {16'h8, 16'h8} : '0;
            bus_error <= (k == 1) ? 16'h8 : 16'h0;
            chan_disable <= (k == 2) ? 16'h8 : 16'h0;
            @(posedge aclk);
            {trigger_complete, trigger_start, bus_error, chan_disable} <= '0;
            rd(off_busy_vector);
            chk(d, 32'h0);
            rd(off_pending_vector);
            chk(d, 32'h0);
            rd(off_active_state);
            chk(d & 32'hF, 32'h0);
        end
        $display("test busy pending done");
        {grant_valid, grant_index} <= {1'b1, 5'h05};
        @(posedge aclk);
        {grant_valid, count_load, count_load_value} <= {1'b0, 1'b1, 16'hABCD};
        @(posedge aclk);
        {count_load, count_update, count_update_value} <= {1'b0, 1'b1, 16'h1234};
        @(posedge aclk);
        count_update <= '0;
        rd(off_active_state);
        chk(d, 32'h12348500);
        {grant_valid, grant_index} <= {1'b1, 5'h07};
        @(posedge aclk);
        grant_valid <= '0;
        #1;
        chk({writeback_valid, writeback_index, writeback_count}, {10'h0, 22'h251234});
        @(posedge aclk);
        writeback_done <= '1;
        @(posedge aclk);
        writeback_done <= '0;
        rd(off_active_state);
        chk(d & 32'hFFFF, 32'h0700);
        $display("test active done");
        wr(off_busy_vector, 32'hFFFFFFFF);
        chk({30'h0, r}, {30'h0, resp_okay});
        rd(off_busy_vector);
        chk(d, 32'h0);
        rd(8'h34);
        chk({30'h0, r}, {30'h0, resp_slverr});
        chk(d, 32'h0);
        transfer_start <= 16'h1;
        @(posedge aclk);
        {transfer_start, aresetn} <= '0;
        repeat (3) @(posedge aclk);
        aresetn <= '1;
        rd(off_busy_vector);
        chk(d, reset_value);
        rd(off_active_state);
        chk(d, reset_value);
        $display("test reset done");
        give_verdict;
    end
    initial
    begin
        repeat (3000) @(posedge aclk);
        error_cnt++;
        give_verdict;
    end
endmodule // dma_channel_status_monitor_tb_top
bind dma_channel_status_monitor dma_status_checker dma_status_checker_inst (.aclk, .aresetn,
    .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rresp, .s_axi_rdata, .grant_valid, .writeback_valid, .writeback_index,
    .writeback_count, .writeback_done);
`default_nettype wire
